// file: logic/wss_wakeup_select.sv
// Wakeup source qualification, pin wake and standby control with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Radio field: enabled-only, reserved, always, ignore
// - Tick field: enabled-only, reserved, always, ignore
// - Pin field: enabled-only, reserved, always, ignore
// - Misc field: enabled-only, reserved, always, ignore
// - Sources honoured while in standby
// - Misc event from oscillator, ADC, random generator
// - Pin enable bits gate each pin, reset zero
// - Large package maps port1.7, port3 low, port2
// - Medium package maps port1 low, port0
// - Small package maps port0 bits 6 to 0
// - Enabled pin wakes on high level
// - Low chip select wakes when slave enabled
// - Code seven stops processor clock until wake
// - Pin wake flag, cleared by read or entry
module wss_wakeup_select
   import wss_pkg::*;
(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic [WSS_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [WSS_DATA_W-1:0] s_axi_wdata,
   input wire logic [WSS_STRB_W-1:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [WSS_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [WSS_DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic radio_event_irq,
   input wire logic tick_event,
   input wire logic hf_crystal_osc_ready,
   input wire logic adc_data_ready,
   input wire logic random_gen_ready,
   input wire logic [7:0] port0_in,
   input wire logic [7:0] port1_in,
   input wire logic [7:0] port2_in,
   input wire logic [7:0] port3_in,
   input wire logic slave_chip_select_n,
   output logic misc_event_irq,
   output logic pin_wake_irq,
   output logic wake_req,
   output logic mcu_clk_stop,
   output logic irq
);
   localparam logic [WSS_ADDR_W-1:0] A_PWR_DOWN = {WSS_IDX_PWR_DOWN, WSS_ADDR_LSB};
   localparam logic [WSS_ADDR_W-1:0] A_WAKE_CFG = {WSS_IDX_WAKE_CFG, WSS_ADDR_LSB};
   localparam logic [WSS_ADDR_W-1:0] A_EN_HIGH = {WSS_IDX_EN_HIGH, WSS_ADDR_LSB};
   localparam logic [WSS_ADDR_W-1:0] A_EN_LOW = {WSS_IDX_EN_LOW, WSS_ADDR_LSB};
   localparam logic [WSS_ADDR_W-1:0] A_IRQ_EN1 = {WSS_IDX_IRQ_EN1, WSS_ADDR_LSB};
   localparam logic [WSS_ADDR_W-1:0] A_SLAVE_CTRL = {WSS_IDX_SLAVE_CTRL, WSS_ADDR_LSB};
   localparam logic [WSS_ADDR_W-1:0] A_PKG_SEL = {WSS_IDX_PKG_SEL, WSS_ADDR_LSB};
   localparam logic [WSS_ADDR_W-1:0] A_STATUS = {WSS_IDX_STATUS, WSS_ADDR_LSB};
   localparam logic [WSS_ADDR_W-1:0] A_MASK = {WSS_IDX_MASK, WSS_ADDR_LSB};
   localparam int PAD_W = WSS_DATA_W - WSS_BYTE_W;

   typedef struct packed {
      logic [7:0] wake_source_config;
      logic [7:0] pin_wake_enable_high;
      logic [7:0] pin_wake_enable_low;
      logic [7:0] irq_enable_reg_one;
      logic [7:0] serial_slave_ctrl_zero;
      logic [1:0] pkg_sel;
      logic [WSS_PD_MODE_W-1:0] prev_mode;
      logic pin_flag;
      logic tick_flag;
      wss_pwr_type pwr;
      logic clk_stop;
      logic wake_req;
      logic misc_irq;
      logic pin_irq;
      logic [WSS_NIRQ-1:0] status;
      logic [WSS_NIRQ-1:0] mask;
      logic irq;
      logic aw_full;
      logic [WSS_ADDR_W-1:0] aw_addr;
      logic w_full;
      logic [WSS_DATA_W-1:0] w_data;
      logic w_strb0;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [WSS_DATA_W-1:0] rdata;
      logic [1:0] rresp;
   } wss_state_type;

   wss_state_type s;
   wss_state_type next_s;
   wss_pin_if pins ();
   logic [2*WSS_BYTE_W-1:0] pin_vec;
   logic pin_hit;
   logic [WSS_NSRC-1:0] src_event;
   logic [WSS_NSRC-1:0] src_qual;

   // Pin synchroniser
   wss_pin_sync u_sync (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .port0_in(port0_in),
      .port1_in(port1_in),
      .port2_in(port2_in),
      .port3_in(port3_in),
      .slave_chip_select_n(slave_chip_select_n),
      .pins(pins.sync)
   );

   // Package dependent pin map, high enable byte first
   always_comb begin
      case (s.pkg_sel)
         WSS_PKG_48: pin_vec = {pins.p1[WSS_PIN_TOP], pins.p3[WSS_PIN_SUB:0], pins.p2};
         WSS_PKG_32: pin_vec = {1'b0, pins.p1[WSS_PIN_SUB:0], pins.p0};
         WSS_PKG_24: pin_vec = {{WSS_BYTE_W{1'b0}}, 1'b0, pins.p0[WSS_PIN_SUB:0]};
         default: pin_vec = '0;
      endcase
   end

   // Enabled high pins plus chip select term
   assign pin_hit = |(pin_vec & {s.pin_wake_enable_high, s.pin_wake_enable_low})
      | (s.serial_slave_ctrl_zero[WSS_SPI_EN_BIT] & ~pins.cs_n);

   assign src_event = {s.misc_irq, s.pin_irq, tick_event, radio_event_irq};

   // Per source qualification from the configuration field
   for (genvar i = 0; i < WSS_NSRC; i++) begin : g_qual
      logic [WSS_FLD_W-1:0] code;
      assign code = s.wake_source_config[WSS_FLD_LSB[i] +: WSS_FLD_W];
      assign src_qual[i] = src_event[i] &
         ((code == WSS_WAKE_IF_EN && s.irq_enable_reg_one[WSS_IEN_BIT[i]])
         || code == WSS_WAKE_ALWAYS);
   end

   // Next state: bus slave, power control, events
   always_comb begin
      logic [WSS_NIRQ-1:0] irq_set;
      logic [WSS_NIRQ-1:0] irq_clr;
      irq_set = '0;
      irq_clr = '0;
      next_s = s;
      next_s.wake_req = 1'b0;
      next_s.misc_irq = hf_crystal_osc_ready | adc_data_ready | random_gen_ready;
      next_s.pin_irq = pin_hit;
      irq_set[WSS_IRQ_MISC] = next_s.misc_irq & ~s.misc_irq;
      // Address and data taken in either order
      if (s_axi_awvalid && s.awready) begin
         next_s.aw_full = 1'b1;
         next_s.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s.wready) begin
         next_s.w_full = 1'b1;
         next_s.w_data = s_axi_wdata;
         next_s.w_strb0 = s_axi_wstrb[0];
      end
      if (s.bvalid && s_axi_bready) begin
         next_s.bvalid = 1'b0;
      end
      // Perform the write once both halves are held
      if (s.aw_full && s.w_full && !s.bvalid) begin
         next_s.aw_full = 1'b0;
         next_s.w_full = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = WSS_RESP_OKAY;
         case (s.aw_addr)
            A_WAKE_CFG: begin
               if (s.w_strb0) begin
                  next_s.wake_source_config = s.w_data[WSS_BYTE_W-1:0];
               end
            end
            A_EN_HIGH: begin
               if (s.w_strb0) begin
                  next_s.pin_wake_enable_high = s.w_data[WSS_BYTE_W-1:0];
               end
            end
            A_EN_LOW: begin
               if (s.w_strb0) begin
                  next_s.pin_wake_enable_low = s.w_data[WSS_BYTE_W-1:0];
               end
            end
            A_IRQ_EN1: begin
               if (s.w_strb0) begin
                  next_s.irq_enable_reg_one = s.w_data[WSS_BYTE_W-1:0];
               end
            end
            A_SLAVE_CTRL: begin
               if (s.w_strb0) begin
                  next_s.serial_slave_ctrl_zero = s.w_data[WSS_BYTE_W-1:0];
               end
            end
            A_PKG_SEL: begin
               if (s.w_strb0) begin
                  next_s.pkg_sel = s.w_data[1:0];
               end
            end
            A_PWR_DOWN: begin
               if (s.w_strb0 && s.w_data[WSS_PD_MODE_W-1:0] != WSS_PD_NONE) begin
                  next_s.prev_mode = s.w_data[WSS_PD_MODE_W-1:0];
                  next_s.pin_flag = 1'b0;
                  next_s.tick_flag = 1'b0;
                  if (s.w_data[WSS_PD_MODE_W-1:0] == WSS_PD_STANDBY) begin
                     next_s.pwr = WSS_STANDBY;
                     next_s.clk_stop = 1'b1;
                  end
               end
            end
            A_STATUS: begin
               if (s.w_strb0) begin
                  irq_clr = s.w_data[WSS_NIRQ-1:0];
               end
            end
            A_MASK: begin
               if (s.w_strb0) begin
                  next_s.mask = s.w_data[WSS_NIRQ-1:0];
               end
            end
            default: next_s.bresp = WSS_RESP_SLVERR;
         endcase
      end
      next_s.awready = !next_s.aw_full && !next_s.bvalid;
      next_s.wready = !next_s.w_full && !next_s.bvalid;
      // Read channel, data captured at the address handshake
      if (s.rvalid && s_axi_rready) begin
         next_s.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s.arready) begin
         next_s.rvalid = 1'b1;
         next_s.rresp = WSS_RESP_OKAY;
         next_s.rdata = '0;
         case (s_axi_araddr)
            A_WAKE_CFG: next_s.rdata = {{PAD_W{1'b0}}, s.wake_source_config};
            A_EN_HIGH: next_s.rdata = {{PAD_W{1'b0}}, s.pin_wake_enable_high};
            A_EN_LOW: next_s.rdata = {{PAD_W{1'b0}}, s.pin_wake_enable_low};
            A_IRQ_EN1: next_s.rdata = {{PAD_W{1'b0}}, s.irq_enable_reg_one};
            A_SLAVE_CTRL: next_s.rdata = {{PAD_W{1'b0}}, s.serial_slave_ctrl_zero};
            A_PKG_SEL: next_s.rdata[1:0] = s.pkg_sel;
            A_PWR_DOWN: begin
               next_s.rdata[WSS_PD_PIN_BIT] = s.pin_flag;
               next_s.rdata[WSS_PD_TICK_BIT] = s.tick_flag;
               next_s.rdata[WSS_PD_MODE_W-1:0] = s.prev_mode;
               next_s.pin_flag = 1'b0;
               next_s.tick_flag = 1'b0;
            end
            A_STATUS: next_s.rdata[WSS_NIRQ-1:0] = s.status;
            A_MASK: next_s.rdata[WSS_NIRQ-1:0] = s.mask;
            default: next_s.rresp = WSS_RESP_SLVERR;
         endcase
      end
      next_s.arready = !next_s.rvalid;
      // Wake from standby; flag set wins over read clear
      if (s.pwr == WSS_STANDBY && |src_qual) begin
         next_s.pwr = WSS_ACTIVE;
         next_s.clk_stop = 1'b0;
         next_s.wake_req = 1'b1;
         irq_set[WSS_IRQ_WAKE] = 1'b1;
         if (src_qual[WSS_SRC_PIN]) begin
            next_s.pin_flag = 1'b1;
            irq_set[WSS_IRQ_PIN] = 1'b1;
         end
         if (src_qual[WSS_SRC_TICK]) begin
            next_s.tick_flag = 1'b1;
         end
      end
      // Sticky status, set wins over write-one clear
      next_s.status = (s.status & ~irq_clr) | irq_set;
      next_s.irq = |(next_s.status & next_s.mask);
   end

   // State register
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // Outputs straight from the state
   assign s_axi_awready = s.awready;
   assign s_axi_wready = s.wready;
   assign s_axi_bresp = s.bresp;
   assign s_axi_bvalid = s.bvalid;
   assign s_axi_arready = s.arready;
   assign s_axi_rdata = s.rdata;
   assign s_axi_rresp = s.rresp;
   assign s_axi_rvalid = s.rvalid;
   assign misc_event_irq = s.misc_irq;
   assign pin_wake_irq = s.pin_irq;
   assign wake_req = s.wake_req;
   assign mcu_clk_stop = s.clk_stop;
   assign irq = s.irq;

   // Checks on qualification and standby behaviour
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   sequence seq_standby_qual;
      s.pwr == WSS_STANDBY && |src_qual;
   endsequence

   sequence seq_wake_out;
      wake_req && !mcu_clk_stop ##1 !wake_req;
   endsequence

   AST_RADIO_IGNORE: assert property (
      s.wake_source_config[WSS_FLD_LSB[0] +: WSS_FLD_W] == WSS_WAKE_IGNORE |-> !src_qual[0])
      else $error("ignored radio source qualified");
   AST_TICK_NEEDS_EN: assert property (
      s.wake_source_config[WSS_FLD_LSB[1] +: WSS_FLD_W] == WSS_WAKE_IF_EN
      && !s.irq_enable_reg_one[WSS_IEN_BIT[1]] |-> !src_qual[1])
      else $error("tick qualified without its enable");
   AST_PIN_ALWAYS: assert property (
      s.wake_source_config[WSS_FLD_LSB[2] +: WSS_FLD_W] == WSS_WAKE_ALWAYS && pin_wake_irq
      |-> src_qual[2])
      else $error("pin source set to always did not qualify");
   AST_MISC_RESERVED: assert property (
      s.wake_source_config[WSS_FLD_LSB[3] +: WSS_FLD_W] == WSS_WAKE_RSVD |-> !src_qual[3])
      else $error("reserved misc code qualified");
   AST_WAKE_PULSE: assert property (seq_standby_qual |=> seq_wake_out)
      else $error("wake request not a single pulse after qualified event");
   AST_WAKE_CAUSE: assert property (
      $rose(wake_req) |-> $past(s.pwr == WSS_STANDBY) && $past(|src_qual))
      else $error("wake request without qualified source in standby");
   AST_STANDBY_HOLD: assert property (
      s.pwr == WSS_STANDBY && !(|src_qual) |=> mcu_clk_stop && !wake_req)
      else $error("clock restarted without a wake event");
   AST_PIN_FLAG: assert property (
      seq_standby_qual and src_qual[WSS_SRC_PIN] |=> s.pin_flag)
      else $error("pin wake flag not recorded");
   AST_PIN_LEVEL: assert property (
      s.pkg_sel == WSS_PKG_48 && s.pin_wake_enable_low[0] && pins.p2[0] |=> pin_wake_irq)
      else $error("pin wake interrupt does not follow pin level");
   AST_MISC_SRC: assert property (
      hf_crystal_osc_ready || adc_data_ready || random_gen_ready |=> misc_event_irq)
      else $error("misc interrupt missing after source event");
endmodule
`default_nettype wire

// file: logic/wss_pkg.sv
// Constants and types shared by the wakeup source select block
package wss_pkg;

   // AXI4-Lite geometry and answers
   localparam int WSS_ADDR_W = 10;
   localparam int WSS_DATA_W = 32;
   localparam int WSS_STRB_W = 4;
   localparam int WSS_BYTE_W = 8;
   localparam logic [1:0] WSS_RESP_OKAY = 2'h0;
   localparam logic [1:0] WSS_RESP_SLVERR = 2'h2;

   // Register indexes; byte address is four times the index
   localparam logic [7:0] WSS_IDX_PWR_DOWN = 8'ha4;
   localparam logic [7:0] WSS_IDX_WAKE_CFG = 8'ha5;
   localparam logic [7:0] WSS_IDX_EN_HIGH = 8'hce;
   localparam logic [7:0] WSS_IDX_EN_LOW = 8'hcf;
   localparam logic [7:0] WSS_IDX_IRQ_EN1 = 8'he0;
   localparam logic [7:0] WSS_IDX_SLAVE_CTRL = 8'he1;
   localparam logic [7:0] WSS_IDX_PKG_SEL = 8'he2;
   localparam logic [7:0] WSS_IDX_STATUS = 8'he3;
   localparam logic [7:0] WSS_IDX_MASK = 8'he4;
   localparam logic [1:0] WSS_ADDR_LSB = 2'h0;

   // Wake source field codes
   localparam int WSS_FLD_W = 2;
   localparam logic [1:0] WSS_WAKE_IF_EN = 2'h0;
   localparam logic [1:0] WSS_WAKE_RSVD = 2'h1;
   localparam logic [1:0] WSS_WAKE_ALWAYS = 2'h2;
   localparam logic [1:0] WSS_WAKE_IGNORE = 2'h3;

   // Sources: 0 radio, 1 tick, 2 pin, 3 misc
   localparam int WSS_NSRC = 4;
   localparam int WSS_SRC_RADIO = 0;
   localparam int WSS_SRC_TICK = 1;
   localparam int WSS_SRC_PIN = 2;
   localparam int WSS_SRC_MISC = 3;
   localparam int WSS_FLD_LSB [WSS_NSRC] = '{6, 4, 2, 0};
   localparam int WSS_IEN_BIT [WSS_NSRC] = '{1, 5, 3, 4};

   // Power down control fields
   localparam int WSS_PD_MODE_W = 3;
   localparam logic [2:0] WSS_PD_NONE = 3'h0;
   localparam logic [2:0] WSS_PD_STANDBY = 3'h7;
   localparam int WSS_PD_PIN_BIT = 7;
   localparam int WSS_PD_TICK_BIT = 6;

   // Package variants and pin positions
   localparam logic [1:0] WSS_PKG_48 = 2'h0;
   localparam logic [1:0] WSS_PKG_32 = 2'h1;
   localparam logic [1:0] WSS_PKG_24 = 2'h2;
   localparam int WSS_PIN_TOP = 7;
   localparam int WSS_PIN_SUB = 6;
   localparam int WSS_SPI_EN_BIT = 0;

   // Interrupt status bits
   localparam int WSS_NIRQ = 3;
   localparam int WSS_IRQ_WAKE = 0;
   localparam int WSS_IRQ_PIN = 1;
   localparam int WSS_IRQ_MISC = 2;

   typedef enum logic {WSS_ACTIVE, WSS_STANDBY} wss_pwr_type;

endpackage

// file: logic/wss_pin_if.sv
// Synchronised wake pins passed from the synchroniser to the core
`timescale 1ns/1ps
`default_nettype none
interface wss_pin_if;
   logic [7:0] p0;
   logic [7:0] p1;
   logic [7:0] p2;
   logic [7:0] p3;
   logic cs_n;
   modport sync (output p0, output p1, output p2, output p3, output cs_n);
   modport core (input p0, input p1, input p2, input p3, input cs_n);
endinterface
`default_nettype wire

// file: logic/wss_pin_sync.sv
// Two-stage synchroniser for the wake pins and the slave chip select
`timescale 1ns/1ps
`default_nettype none
module wss_pin_sync
   import wss_pkg::*;
(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic [7:0] port0_in,
   input wire logic [7:0] port1_in,
   input wire logic [7:0] port2_in,
   input wire logic [7:0] port3_in,
   input wire logic slave_chip_select_n,
   wss_pin_if.sync pins
);
   localparam int WSS_SYNC_W = 4 * WSS_BYTE_W + 1;

   typedef struct packed {
      logic [WSS_SYNC_W-1:0] meta;
      logic [WSS_SYNC_W-1:0] stable;
   } wss_sync_type;

   wss_sync_type s;
   wss_sync_type next_s;

   // First stage feeds only the second stage
   always_comb begin
      next_s = s;
      next_s.meta = {slave_chip_select_n, port3_in, port2_in, port1_in, port0_in};
      next_s.stable = s.meta;
   end

   // Chip select idles high so it resets to the inactive level
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         s <= '{meta: {1'b1, {(WSS_SYNC_W-1){1'b0}}}, stable: {1'b1, {(WSS_SYNC_W-1){1'b0}}}};
      end else begin
         s <= next_s;
      end
   end

   // Hand the stable copies to the core
   assign {pins.cs_n, pins.p3, pins.p2, pins.p1, pins.p0} = s.stable;
endmodule
`default_nettype wire

// file: bench/wss_src_model.sv
// Far-side model: interrupt sources, wake pins and slave select
`timescale 1ns/1ps
`default_nettype none
module wss_src_model (
   output logic radio_event_irq,
   output logic tick_event,
   output logic hf_crystal_osc_ready,
   output logic adc_data_ready,
   output logic random_gen_ready,
   output logic [7:0] port0_in,
   output logic [7:0] port1_in,
   output logic [7:0] port2_in,
   output logic [7:0] port3_in,
   output logic slave_chip_select_n
);
   // Sources quiet, pins low, select released
   initial begin
      {radio_event_irq, tick_event, hf_crystal_osc_ready} = 3'h0;
      {adc_data_ready, random_gen_ready} = 2'h0;
      {port3_in, port2_in, port1_in, port0_in} = 32'h0000_0000;
      slave_chip_select_n = 1'b1;
   end
   // Event levels: 0 radio, 1 tick, 3 adc, 4 oscillator, 5 random
   task automatic set_evt(input int s, input logic v);
      case (s)
         0: radio_event_irq <= v;
         1: tick_event <= v;
         4: hf_crystal_osc_ready <= v;
         5: random_gen_ready <= v;
         default: adc_data_ready <= v;
      endcase
   endtask
   // All four ports at once, port0 in the low byte
   task automatic set_ports(input logic [31:0] v);
      {port3_in, port2_in, port1_in, port0_in} <= v;
   endtask
   task automatic set_cs(input logic v);
      slave_chip_select_n <= v;
   endtask
endmodule
`default_nettype wire

// file: bench/wakeup_source_select_test.sv
// Self-checking bench for the wakeup source select block
`timescale 1ns/1ps
`default_nettype none
module wakeup_source_select_test
   import wss_pkg::*;
;
   logic ref_clk, arst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [WSS_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [WSS_DATA_W-1:0] s_axi_wdata, s_axi_rdata;
   logic [WSS_STRB_W-1:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic radio_event_irq, tick_event, hf_crystal_osc_ready, adc_data_ready, random_gen_ready;
   logic [7:0] port0_in, port1_in, port2_in, port3_in;
   logic slave_chip_select_n, misc_event_irq, pin_wake_irq, wake_req, mcu_clk_stop, irq;
   int fail_count = 0;
   int tests_run = 0;

   wss_wakeup_select dut (.ref_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .radio_event_irq, .tick_event,
      .hf_crystal_osc_ready, .adc_data_ready, .random_gen_ready, .port0_in, .port1_in,
      .port2_in, .port3_in, .slave_chip_select_n, .misc_event_irq, .pin_wake_irq,
      .wake_req, .mcu_clk_stop, .irq);
   wss_src_model src (.radio_event_irq, .tick_event, .hf_crystal_osc_ready,
      .adc_data_ready, .random_gen_ready, .port0_in, .port1_in, .port2_in, .port3_in,
      .slave_chip_select_n);

   // 10 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH time=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic finish_test();
      if (fail_count == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Wait n edges, then settle to mid-cycle
   task automatic look(input int n);
      repeat (n) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask

   // Write: both channels offered, each released once taken
   task automatic axi_wr(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] rsp);
      logic a, w, ra, rw;
      @(posedge ref_clk);
      s_axi_awaddr <= {idx, 2'h0};
      s_axi_wdata <= {24'h00_0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      a = 1'b1;
      w = 1'b1;
      while (a || w) begin
         @(negedge ref_clk);
         ra = s_axi_awready & a;
         rw = s_axi_wready & w;
         @(posedge ref_clk);
         if (ra) s_axi_awvalid <= 1'b0;
         if (rw) s_axi_wvalid <= 1'b0;
         a = a & ~ra;
         w = w & ~rw;
      end
      do begin
         @(negedge ref_clk);
         ra = s_axi_bvalid;
         rsp = s_axi_bresp;
         @(posedge ref_clk);
      end while (ra !== 1'b1);
      s_axi_bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] rsp);
      logic r;
      @(posedge ref_clk);
      s_axi_araddr <= {idx, 2'h0};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(negedge ref_clk);
         r = s_axi_arready;
         @(posedge ref_clk);
      end while (r !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(negedge ref_clk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge ref_clk);
      s_axi_rready <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [1:0] r;
      axi_wr(idx, d, r);
   endtask

   task automatic rd_chk(input logic [7:0] idx, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      axi_rd(idx, d, r);
      chk(d, e);
   endtask

   // Reset values, read-back and unmapped place
   task automatic t_regs();
      logic [31:0] d;
      logic [1:0] r;
      rd_chk(WSS_IDX_WAKE_CFG, 32'h0000_0000);
      rd_chk(WSS_IDX_EN_HIGH, 32'h0000_0000);
      rd_chk(WSS_IDX_EN_LOW, 32'h0000_0000);
      wr(WSS_IDX_EN_HIGH, 8'h5a);
      rd_chk(WSS_IDX_EN_HIGH, 32'h0000_005a);
      axi_wr(8'h10, 8'hff, r);
      chk(r, WSS_RESP_SLVERR);
      axi_rd(8'h10, d, r);
      chk(r, WSS_RESP_SLVERR);
   endtask

   // Raise or drop one wake source; pin source is port2 pin 0
   task automatic drive(input int s, input logic v);
      @(posedge ref_clk);
      if (s == WSS_SRC_PIN) src.set_ports(v ? 32'h0001_0000 : 32'h0000_0000);
      else src.set_evt(s, v);
   endtask

   // Every field code per source, entered from standby
   task automatic t_wake();
      logic [1:0] code [5] = '{WSS_WAKE_IF_EN, WSS_WAKE_IF_EN, WSS_WAKE_ALWAYS,
         WSS_WAKE_IGNORE, WSS_WAKE_RSVD};
      logic ien [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
      logic expw [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
      int pulses;
      wr(WSS_IDX_PKG_SEL, {6'h00, WSS_PKG_48});
      wr(WSS_IDX_EN_LOW, 8'h01);
      for (int s = 0; s < WSS_NSRC; s++) begin
         for (int c = 0; c < 5; c++) begin
            wr(WSS_IDX_IRQ_EN1, ien[c] ? 8'h01 << WSS_IEN_BIT[s] : 8'h00);
            wr(WSS_IDX_WAKE_CFG, ~(8'h03 << WSS_FLD_LSB[s]) | ({6'h00, code[c]} << WSS_FLD_LSB[s]));
            wr(WSS_IDX_PWR_DOWN, {5'h00, WSS_PD_STANDBY});
            @(negedge ref_clk);
            chk(mcu_clk_stop, 1'b1);
            drive(s, 1'b1);
            pulses = 0;
            repeat (8) begin
               @(negedge ref_clk);
               if (wake_req === 1'b1) pulses++;
            end
            chk(pulses, expw[c]);
            chk(mcu_clk_stop, !expw[c]);
            if (s == WSS_SRC_PIN && expw[c]) begin
               rd_chk(WSS_IDX_PWR_DOWN, 32'h0000_0087);
               rd_chk(WSS_IDX_PWR_DOWN, 32'h0000_0007);
            end
            drive(s, 1'b0);
            look(5);
         end
      end
   endtask

   // {used, port, pin} reached by enable bit k (high register is k 8..15)
   function automatic logic [5:0] pmap(input int p, input int k);
      if (p > WSS_PKG_24) return 6'h00;
      if (k == 15) return (p == WSS_PKG_48) ? 6'h2f : 6'h00;
      if (k > 7) return (p == WSS_PKG_24) ? 6'h00 :
         {1'b1, (p == WSS_PKG_48) ? 2'h3 : 2'h1, 3'(k - 8)};
      if (p == WSS_PKG_48) return {1'b1, 2'h2, 3'(k)};
      return (p == WSS_PKG_24 && k == 7) ? 6'h00 : {1'b1, 2'h0, 3'(k)};
   endfunction

   // Each enable bit alone, each package, pin high then low
   task automatic t_map();
      logic [5:0] m;
      for (int p = 0; p < 4; p++) begin
         wr(WSS_IDX_PKG_SEL, 8'(p));
         for (int k = 0; k < 16; k++) begin
            m = pmap(p, k);
            wr(WSS_IDX_EN_HIGH, k > 7 ? 8'h01 << (k - 8) : 8'h00);
            wr(WSS_IDX_EN_LOW, k < 8 ? 8'h01 << k : 8'h00);
            @(posedge ref_clk);
            src.set_ports(m[5] ? 32'h0000_0001 << m[4:0] : 32'hffff_ffff);
            look(5);
            chk(pin_wake_irq, m[5]);
            @(posedge ref_clk);
            src.set_ports(32'h0000_0000);
            look(5);
            chk(pin_wake_irq, 1'b0);
         end
      end
   endtask

   // Slave select as a low-active wake term
   task automatic t_cs();
      wr(WSS_IDX_EN_HIGH, 8'h00);
      wr(WSS_IDX_EN_LOW, 8'h00);
      @(posedge ref_clk);
      src.set_ports(32'hffff_ffff);
      src.set_cs(1'b0);
      look(5);
      chk(pin_wake_irq, 1'b0);
      wr(WSS_IDX_SLAVE_CTRL, 8'h01);
      look(4);
      chk(pin_wake_irq, 1'b1);
      @(posedge ref_clk);
      src.set_cs(1'b1);
      look(5);
      chk(pin_wake_irq, 1'b0);
      @(posedge ref_clk);
      src.set_ports(32'h0000_0000);
      wr(WSS_IDX_SLAVE_CTRL, 8'h00);
   endtask

   // Misc event sources, sticky status, mask and clear
   task automatic t_misc();
      int ev [3] = '{4, 3, 5};
      wr(WSS_IDX_MASK, 8'h04);
      for (int i = 0; i < 3; i++) begin
         wr(WSS_IDX_STATUS, 8'h07);
         @(posedge ref_clk);
         src.set_evt(ev[i], 1'b1);
         look(1);
         chk(misc_event_irq, 1'b1);
         @(posedge ref_clk);
         src.set_evt(ev[i], 1'b0);
         look(3);
         chk(misc_event_irq, 1'b0);
         chk(irq, 1'b1);
         wr(WSS_IDX_STATUS, 8'h04);
         look(2);
         chk(irq, 1'b0);
      end
      wr(WSS_IDX_MASK, 8'h00);
      drive(WSS_SRC_MISC, 1'b1);
      drive(WSS_SRC_MISC, 1'b0);
      look(3);
      chk(irq, 1'b0);
      rd_chk(WSS_IDX_STATUS, 32'h0000_0004);
   endtask

   // Hang guard
   initial begin
      #8_000_000;
      fail_count++;
      finish_test();
   end

   // Reset, then the scenarios in turn
   initial begin
      arst_n = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      s_axi_awaddr = '0;
      s_axi_araddr = '0;
      s_axi_wdata = 32'h0000_0000;
      s_axi_wstrb = 4'hf;
      repeat (8) @(posedge ref_clk);
      arst_n <= 1'b1;
      look(2);
      t_regs();
      t_wake();
      t_map();
      t_cs();
      t_misc();
      finish_test();
   end
endmodule
`default_nettype wire
